/* lbc_pkg.sv */
package lbc_pkg;
  // Register offsets
  localparam logic [7:0] LBC_ADDR_CTRL  = 8'h09;
  localparam logic [7:0] LBC_ADDR_RAMP  = 8'h0a;
  localparam logic [7:0] LBC_ADDR_FILT  = 8'h0b;
  localparam logic [7:0] LBC_ADDR_BOOST = 8'h0c;
  // Reset values
  localparam logic [7:0] LBC_RST_CTRL  = 8'h18;
  localparam logic [7:0] LBC_RST_RAMP  = 8'h11;
  localparam logic [7:0] LBC_RST_FILT  = 8'h00;
  localparam logic [7:0] LBC_RST_BOOST = 8'h28;
  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] LBC_MASK_CTRL  = 8'h9f;
  localparam logic [7:0] LBC_MASK_RAMP  = 8'hff;
  localparam logic [7:0] LBC_MASK_FILT  = 8'h0f;
  localparam logic [7:0] LBC_MASK_BOOST = 8'h3f;
  // Control register fields
  localparam int LBC_BIT_MASTER   = 7;
  localparam int LBC_BIT_POS_DIS  = 4;
  localparam int LBC_BIT_NEG_DIS  = 3;
  localparam int LBC_BIT_POS_EN   = 2;
  localparam int LBC_BIT_NEG_EN   = 1;
  localparam int LBC_BIT_PIN_SEL  = 0;
  // Ramp and fault mode fields
  localparam int LBC_SHORT_MODE_HI = 7;
  localparam int LBC_SHORT_MODE_LO = 6;
  localparam int LBC_POS_RISE_HI   = 5;
  localparam int LBC_POS_RISE_LO   = 4;
  localparam int LBC_NEG_FALL_HI   = 3;
  localparam int LBC_NEG_FALL_LO   = 0;
  // Short filter fields
  localparam int LBC_POS_FILT_HI = 3;
  localparam int LBC_POS_FILT_LO = 2;
  localparam int LBC_NEG_FILT_HI = 1;
  localparam int LBC_NEG_FILT_LO = 0;
  // Voltage codes, 50 mV units above 4 V
  localparam logic [6:0] LBC_BASE_UNITS = 7'h50;      // 4 V in 50 mV units
  localparam logic [5:0] LBC_BOOST_SAT  = 6'h34;      // 6.6 V
  localparam logic [5:0] LBC_OUT_SAT    = 6'h2e;      // 6.3 V
  // Timing
  localparam int LBC_CLK_NS          = 50;
  localparam int LBC_POS_RAMP_US     = 228;           // per code step, nominal
  localparam int LBC_NEG_RAMP_US     = 456;           // per code step, nominal
  localparam int LBC_RAMP_NOM_STEPS  = 115;           // 5.75 V in 50 mV steps
  localparam int LBC_POS_STEP_CYC    = (LBC_POS_RAMP_US * 1000 / LBC_CLK_NS) / LBC_RAMP_NOM_STEPS;
  localparam int LBC_NEG_STEP_CYC    = (LBC_NEG_RAMP_US * 1000 / LBC_CLK_NS) / LBC_RAMP_NOM_STEPS;
  localparam int LBC_FILT_2MS_US     = 2000;
  localparam int LBC_FILT_1MS_US     = 1000;
  localparam int LBC_FILT_500US_US   = 500;
  localparam int LBC_FILT_100US_US   = 100;
  localparam int LBC_FILT_2MS_CYC    = LBC_FILT_2MS_US * 1000 / LBC_CLK_NS;
  localparam int LBC_FILT_1MS_CYC    = LBC_FILT_1MS_US * 1000 / LBC_CLK_NS;
  localparam int LBC_FILT_500US_CYC  = LBC_FILT_500US_US * 1000 / LBC_CLK_NS;
  localparam int LBC_FILT_100US_CYC  = LBC_FILT_100US_US * 1000 / LBC_CLK_NS;
endpackage

/* lbc_bias_ctrl.sv */
`timescale 1ns/100ps

// Short qualifier: one pulse once raw has held for limit cycles
module lbc_short_filter (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        raw,
  input  wire logic [15:0] limit,
  output logic             hit
);

  logic [15:0] cnt_r;
  logic        done_r;

  // Count while short persists; a release restarts the qualification
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 16'h0000;
      done_r <= 1'b0;
    end else if (!raw) begin
      cnt_r  <= 16'h0000;
      done_r <= 1'b0;
    end else if (!done_r) begin
      done_r <= (cnt_r + 16'h0001 >= limit);
      cnt_r  <= cnt_r + 16'h0001;
    end
  end

  assign hit = raw && !done_r && (cnt_r + 16'h0001 >= limit);
endmodule

// Fixed-slew ramp of output level in 50 mV units
module lbc_ramp (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        on,
  input  wire logic [6:0]  target,
  input  wire logic [11:0] step_cyc,
  output logic      [6:0]  level
);

  logic [11:0] tick_r;

  // One 50 mV step per step_cyc, so time scales with target voltage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_r <= 12'h000;
      level  <= 7'h00;
    end else if (!on) begin
      tick_r <= 12'h000;
      level  <= 7'h00;                                // Discharge is analog
    end else if (level != target) begin
      if (tick_r + 12'h001 >= step_cyc) begin
        tick_r <= 12'h000;
        level  <= (level < target) ? level + 7'h01 : level - 7'h01;
      end else begin
        tick_r <= tick_r + 12'h001;
      end
    end else begin
      tick_r <= 12'h000;
    end
  end
endmodule

// Function
// - Master enable low keeps the whole bias supply off.
// - Positive discharge bit enables positive pulldown while that output is off.
// - Negative discharge bit enables negative pulldown while that output is off.
// - Pin select low: outputs enabled only by their register bits.
// - Pin select high: outputs enabled only by the enable pins.
// - Short mode: 0X flag only, 10 shuts outputs, 11 also backlight.
// - Positive rise field picks 228/456/684/912 us, reset code 01.
// - Negative fall field picks (code+1)*456 us, reset code 0001.
// - Positive ramp fixed slew; time nominal at 5.75 V, scales with target.
// - Negative ramp fixed slew; time scales with magnitude of target.
// - Positive short filter: 2ms, 1ms, 500us, 100us; default 00.
// - Negative short filter uses same four times; default 00.
// - Boost code is 4 V plus 50 mV steps, saturating at 6.6 V.
// - New output voltage codes apply only when control register rewritten.
// - Software reset returns all registers to reset values; the soft_reset request is a level input that the host must drop.
module lbc_bias_ctrl
  import lbc_pkg::*;
#(
  parameter int FILT_2MS_CYC   = LBC_FILT_2MS_CYC,
  parameter int FILT_1MS_CYC   = LBC_FILT_1MS_CYC,
  parameter int FILT_500US_CYC = LBC_FILT_500US_CYC
) (
  core_clk,
  rst,
  soft_reset,
  reg_wr,
  reg_rd,
  reg_addr,
  reg_wdata,
  reg_rdata,
  pos_code_req,
  neg_code_req,
  pos_enable_pin,
  neg_enable_pin,
  pos_short_raw,
  neg_short_raw,
  bias_supply_on,
  pos_out_on,
  neg_out_on,
  pos_pulldown_on,
  neg_pulldown_on,
  pos_short_event,
  neg_short_event,
  backlight_shutdown,
  pos_level,
  neg_level,
  boost_code
);
  input  wire logic       core_clk;
  input  wire logic       rst;
  input  wire logic       soft_reset;
  input  wire logic       reg_wr;
  input  wire logic       reg_rd;
  input  wire logic [7:0] reg_addr;
  input  wire logic [7:0] reg_wdata;
  output logic      [7:0] reg_rdata;
  input  wire logic [5:0] pos_code_req;
  input  wire logic [5:0] neg_code_req;
  input  wire logic       pos_enable_pin;
  input  wire logic       neg_enable_pin;
  input  wire logic       pos_short_raw;
  input  wire logic       neg_short_raw;
  output logic            bias_supply_on;
  output logic            pos_out_on;
  output logic            neg_out_on;
  output logic            pos_pulldown_on;
  output logic            neg_pulldown_on;
  output logic            pos_short_event;
  output logic            neg_short_event;
  output logic            backlight_shutdown;
  output logic      [6:0] pos_level;
  output logic      [6:0] neg_level;
  output logic      [5:0] boost_code;

  logic [7:0]  ctrl_r;
  logic [7:0]  ramp_r;
  logic [7:0]  filt_r;
  logic [7:0]  boost_r;
  logic [5:0]  pos_code_r;
  logic [5:0]  neg_code_r;
  logic        outs_shut_r;
  logic        pos_on_nxt;
  logic        neg_on_nxt;
  logic        pos_hit;
  logic        neg_hit;
  logic [15:0] pos_limit;
  logic [15:0] neg_limit;
  logic [11:0] pos_step;
  logic [11:0] neg_step;
  logic        ctrl_wr;

  assign ctrl_wr = reg_wr && (reg_addr == LBC_ADDR_CTRL);

  // Register writes; soft reset restores all defaults in one cycle
  // soft reset restore
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r  <= LBC_RST_CTRL;
      ramp_r  <= LBC_RST_RAMP;
      filt_r  <= LBC_RST_FILT;
      boost_r <= LBC_RST_BOOST;
    end else if (soft_reset) begin
      ctrl_r  <= LBC_RST_CTRL;
      ramp_r  <= LBC_RST_RAMP;
      filt_r  <= LBC_RST_FILT;
      boost_r <= LBC_RST_BOOST;
    end else if (reg_wr) begin
      case (reg_addr)
        LBC_ADDR_CTRL:  ctrl_r  <= reg_wdata & LBC_MASK_CTRL;
        LBC_ADDR_RAMP:  ramp_r  <= reg_wdata & LBC_MASK_RAMP;
        LBC_ADDR_FILT:  filt_r  <= reg_wdata & LBC_MASK_FILT;
        LBC_ADDR_BOOST: boost_r <= reg_wdata & LBC_MASK_BOOST;
        default: ;
      endcase
    end
  end

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        LBC_ADDR_CTRL:  reg_rdata <= ctrl_r;
        LBC_ADDR_RAMP:  reg_rdata <= ramp_r;
        LBC_ADDR_FILT:  reg_rdata <= filt_r;
        LBC_ADDR_BOOST: reg_rdata <= boost_r;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // Voltage codes latched only on a control write, so both move together
  // commit on rewrite
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pos_code_r <= 6'h00;
      neg_code_r <= 6'h00;
    end else if (ctrl_wr && !soft_reset) begin
      pos_code_r <= (pos_code_req > LBC_OUT_SAT) ? LBC_OUT_SAT : pos_code_req;
      neg_code_r <= (neg_code_req > LBC_OUT_SAT) ? LBC_OUT_SAT : neg_code_req;
    end
  end

  // Output gating
  // register enables
  always_comb begin
    if (ctrl_r[LBC_BIT_PIN_SEL]) begin
      pos_on_nxt = pos_enable_pin;
      neg_on_nxt = neg_enable_pin;
    end else begin
      pos_on_nxt = ctrl_r[LBC_BIT_POS_EN];
      neg_on_nxt = ctrl_r[LBC_BIT_NEG_EN];
    end
    pos_on_nxt = pos_on_nxt && ctrl_r[LBC_BIT_MASTER] && !outs_shut_r;
    neg_on_nxt = neg_on_nxt && ctrl_r[LBC_BIT_MASTER] && !outs_shut_r;
  end

  // Registered enables and pulldowns
  // positive pulldown
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bias_supply_on  <= 1'b0;
      pos_out_on      <= 1'b0;
      neg_out_on      <= 1'b0;
      pos_pulldown_on <= 1'b0;
      neg_pulldown_on <= 1'b0;
    end else begin
      bias_supply_on  <= ctrl_r[LBC_BIT_MASTER];
      pos_out_on      <= pos_on_nxt;
      neg_out_on      <= neg_on_nxt;
      pos_pulldown_on <= ctrl_r[LBC_BIT_POS_DIS] && !pos_on_nxt;
      neg_pulldown_on <= ctrl_r[LBC_BIT_NEG_DIS] && !neg_on_nxt;
    end
  end

  // Filter time selection
  // positive filter time
  function automatic logic [15:0] filt_sel(input logic [1:0] code);
    case (code)
      2'h0:    filt_sel = 16'(FILT_2MS_CYC);
      2'h1:    filt_sel = 16'(FILT_1MS_CYC);
      2'h2:    filt_sel = 16'(FILT_500US_CYC);
      default: filt_sel = 16'(LBC_FILT_100US_CYC);
    endcase
  endfunction

  assign pos_limit = filt_sel(filt_r[LBC_POS_FILT_HI:LBC_POS_FILT_LO]);
  assign neg_limit = filt_sel(filt_r[LBC_NEG_FILT_HI:LBC_NEG_FILT_LO]);

  lbc_short_filter u_pos_filt (
    .core_clk (core_clk),
    .rst      (rst),
    .raw      (pos_short_raw && pos_out_on),
    .limit    (pos_limit),
    .hit      (pos_hit)
  );

  lbc_short_filter u_neg_filt (
    .core_clk (core_clk),
    .rst      (rst),
    .raw      (neg_short_raw && neg_out_on),
    .limit    (neg_limit),
    .hit      (neg_hit)
  );

  // Short reaction; shutdown holds until the control register is rewritten or soft reset is applied
  // short reaction mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outs_shut_r        <= 1'b0;
      backlight_shutdown <= 1'b0;
      pos_short_event    <= 1'b0;
      neg_short_event    <= 1'b0;
    end else begin
      pos_short_event <= pos_hit;
      neg_short_event <= neg_hit;
      if ((pos_hit || neg_hit) && ramp_r[LBC_SHORT_MODE_HI]) begin
        outs_shut_r <= 1'b1;                          // New short wins over clear
        if (ramp_r[LBC_SHORT_MODE_LO]) begin
          backlight_shutdown <= 1'b1;
        end
      end else if (ctrl_wr || soft_reset) begin
        outs_shut_r        <= 1'b0;
        backlight_shutdown <= 1'b0;
      end
    end
  end

  // Step period per 50 mV so that 5.75 V takes the nominal time
  // positive rise select
  assign pos_step = 12'(({10'h000, ramp_r[LBC_POS_RISE_HI:LBC_POS_RISE_LO]} + 12'h001)
                        * 12'(LBC_POS_STEP_CYC));
  assign neg_step = 12'(({8'h00, ramp_r[LBC_NEG_FALL_HI:LBC_NEG_FALL_LO]} + 12'h001)
                        * 12'(LBC_NEG_STEP_CYC));

  lbc_ramp u_pos_ramp (
    .core_clk (core_clk),
    .rst      (rst),
    .on       (pos_out_on),
    .target   (LBC_BASE_UNITS + {1'b0, pos_code_r}),
    .step_cyc (pos_step),
    .level    (pos_level)
  );

  lbc_ramp u_neg_ramp (
    .core_clk (core_clk),
    .rst      (rst),
    .on       (neg_out_on),
    .target   (LBC_BASE_UNITS + {1'b0, neg_code_r}),
    .step_cyc (neg_step),
    .level    (neg_level)
  );

  // Boost target, clipped at 6.6 V
  // boost saturation
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boost_code <= LBC_RST_BOOST[5:0];
    end else begin
      boost_code <= (boost_r[5:0] > LBC_BOOST_SAT) ? LBC_BOOST_SAT : boost_r[5:0];
    end
  end
endmodule

/* lbc_bias_ctrl_monitor.sv */
`timescale 1ns/100ps
// Port-level checks on the bias control block
module lbc_bias_ctrl_monitor
  import lbc_pkg::*;
#(
  parameter int FILT_500US_CYC = LBC_FILT_500US_CYC
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       soft_reset,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       pos_enable_pin,
  input wire logic       pos_short_raw,
  input wire logic       bias_supply_on,
  input wire logic       pos_out_on,
  input wire logic       neg_out_on,
  input wire logic       pos_pulldown_on,
  input wire logic       neg_pulldown_on,
  input wire logic       pos_short_event,
  input wire logic [5:0] boost_code
);
  // Shortest limit; the 100 us code is fixed at 2000 cycles
  localparam int MIN_LIM = (FILT_500US_CYC < 2000) ? FILT_500US_CYC : 2000;
  logic [15:0] pos_run_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Saturating run length, so a long short never wraps to zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      pos_run_r <= 16'h0000;
    else if (!pos_short_raw)
      pos_run_r <= 16'h0000;
    else if (pos_run_r != 16'hffff)
      pos_run_r <= pos_run_r + 16'h0001;
  end
  sequence s_ctrl_wr(logic [7:0] d);
    reg_wr && reg_addr == LBC_ADDR_CTRL && reg_wdata == d && !soft_reset;
  endsequence
  property p_master_off;
    reg_wr && reg_addr == LBC_ADDR_CTRL && !reg_wdata[7] && !soft_reset
      |-> ##2 !bias_supply_on && !pos_out_on && !neg_out_on;
  endproperty
  property p_reg_mode;
    s_ctrl_wr(8'h84) |-> ##2 pos_out_on && !neg_out_on;
  endproperty
  property p_pin_mode;
    s_ctrl_wr(8'h81) ##2 1'b1 |-> pos_out_on == $past(pos_enable_pin);
  endproperty
  property p_pos_pull;
    pos_pulldown_on |-> !pos_out_on;
  endproperty
  property p_neg_pull;
    neg_pulldown_on |-> !neg_out_on;
  endproperty
  property p_pos_pull_on;
    s_ctrl_wr(8'h90) |-> ##2 pos_pulldown_on && !neg_pulldown_on;
  endproperty
  property p_neg_pull_on;
    s_ctrl_wr(8'h88) |-> ##2 neg_pulldown_on && !pos_pulldown_on;
  endproperty
  property p_soft;
    soft_reset |-> ##2 !bias_supply_on && pos_pulldown_on && neg_pulldown_on;
  endproperty
  property p_boost_sat;
    boost_code <= LBC_BOOST_SAT;
  endproperty
  property p_filt;
    pos_short_event |-> pos_run_r >= MIN_LIM ##1 !pos_short_event;
  endproperty
  a_master_off: assert property (p_master_off) else $error("outputs on with master off");
  a_reg_mode: assert property (p_reg_mode) else $error("register enables not followed");
  a_pin_mode: assert property (p_pin_mode) else $error("pin enable not followed");
  a_pos_pull: assert property (p_pos_pull) else $error("pos pulldown while on");
  a_neg_pull: assert property (p_neg_pull) else $error("neg pulldown while on");
  a_pos_pull_on: assert property (p_pos_pull_on) else $error("pos pulldown not applied");
  a_neg_pull_on: assert property (p_neg_pull_on) else $error("neg pulldown not applied");
  a_soft: assert property (p_soft) else $error("soft reset defaults wrong");
  a_boost_sat: assert property (p_boost_sat) else $error("boost code above limit");
  a_filt: assert property (p_filt) else $error("short event too early or long");
endmodule

bind lbc_bias_ctrl lbc_bias_ctrl_monitor #(.FILT_500US_CYC(FILT_500US_CYC)) u_mon (
  .core_clk, .rst, .soft_reset, .reg_wr, .reg_addr, .reg_wdata, .pos_enable_pin,
  .pos_short_raw, .bias_supply_on, .pos_out_on, .neg_out_on, .pos_pulldown_on,
  .neg_pulldown_on, .pos_short_event, .boost_code
);

/* lbc_host_model.sv */
`timescale 1ns/100ps
// Register host; strobes move on the falling edge, clear of sampling
module lbc_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_addr = 8'h00,
  output logic      [7:0] reg_wdata = 8'h00
);
  // One-cycle write; data inverted after so nothing stale lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // Read data is registered, taken a cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule

/* lbc_bias_ctrl_bench.sv */
`timescale 1ns/100ps
module lbc_bias_ctrl_bench;
  import lbc_pkg::*;
  logic       core_clk, rst, soft_reset, reg_wr, reg_rd;
  logic       pos_enable_pin, neg_enable_pin, pos_short_raw, neg_short_raw;
  logic       bias_supply_on, pos_out_on, neg_out_on, pos_pulldown_on, neg_pulldown_on;
  logic       pos_short_event, neg_short_event, backlight_shutdown;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
  logic [5:0] pos_code_req, neg_code_req, boost_code;
  logic [6:0] pos_level, neg_level;
  int         err_count = 0;
  int         n_compared = 0;
  int         n, m, e;
  logic [7:0] adr[4] = '{LBC_ADDR_CTRL, LBC_ADDR_RAMP, LBC_ADDR_FILT, LBC_ADDR_BOOST};
  logic [7:0] rv[4]  = '{8'h18, 8'h11, 8'h00, 8'h28};
  logic [7:0] mk[4]  = '{8'h9f, 8'hff, 8'h0f, 8'h3f};
  // Control word, pins {pos,neg}, expected flags
  logic [7:0] cw[7]  = '{8'h84, 8'h81, 8'h81, 8'h1f, 8'h90, 8'h88, 8'h86};
  logic [1:0] cp[7]  = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h3, 2'h3, 2'h0};
  logic [7:0] ce[7]  = '{8'h18, 8'h18, 8'h14, 8'h03, 8'h12, 8'h11, 8'h1c};
  // Fault mode, filter code, qualify cycles, flags and backlight after
  logic [7:0] fm[4]  = '{8'h40, 8'h80, 8'hc0, 8'h80};
  logic [7:0] fv[4]  = '{8'h00, 8'h05, 8'h0a, 8'h0f};
  int         fl[4]  = '{40, 20, 10, 2000};
  logic [7:0] fo[4]  = '{8'h1c, 8'h10, 8'h10, 8'h10};
  logic       fb[4]  = '{1'b0, 1'b0, 1'b1, 1'b0};

  // Small filter limits keep the run short
  lbc_bias_ctrl #(.FILT_2MS_CYC(40), .FILT_1MS_CYC(20), .FILT_500US_CYC(10)) dut (
    .core_clk, .rst, .soft_reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .pos_code_req, .neg_code_req, .pos_enable_pin, .neg_enable_pin, .pos_short_raw,
    .neg_short_raw, .bias_supply_on, .pos_out_on, .neg_out_on, .pos_pulldown_on,
    .neg_pulldown_on, .pos_short_event, .neg_short_event, .backlight_shutdown,
    .pos_level, .neg_level, .boost_code
  );
  lbc_host_model host (.core_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [15:0] outs();
    return {11'h0, bias_supply_on, pos_out_on, neg_out_on, pos_pulldown_on, neg_pulldown_on};
  endfunction

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rd_v);
    check("rdata", {8'h00, e}, {8'h00, rd_v});
  endtask

  // Bounded wait for both ramps to settle
  task automatic wait_lvl(input logic [6:0] p, input logic [6:0] q);
    for (n = 0; n < 9000 && {pos_level, neg_level} !== {p, q}; n++)
      @(negedge core_clk);
    check("levels", {2'h0, p, q}, {2'h0, pos_level, neg_level});
    if ({pos_level, neg_level} !== {p, q})
      final_report();
  endtask

  task automatic final_report();
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    {rst, soft_reset, pos_enable_pin, neg_enable_pin} = 4'h8;
    {pos_short_raw, neg_short_raw, pos_code_req, neg_code_req} = 14'h0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    foreach (adr[i]) rdchk(adr[i], rv[i]);
    foreach (adr[i]) begin
      host.wr(adr[i], 8'hff);
      rdchk(adr[i], mk[i]);
    end
    host.wr(8'h20, 8'h55);
    rdchk(8'h20, 8'h00);
    check("boost", 16'h0034, {10'h0, boost_code});
    @(negedge core_clk);
    soft_reset = 1'b1;
    @(negedge core_clk);
    soft_reset = 1'b0;
    foreach (adr[i]) rdchk(adr[i], rv[i]);
    host.wr(LBC_ADDR_BOOST, 8'h33);
    @(negedge core_clk);
    check("boost", 16'h0033, {10'h0, boost_code});
    host.wr(LBC_ADDR_RAMP, 8'h00);
    // Enable sources, master gating and discharge
    foreach (cw[i]) begin
      {pos_enable_pin, neg_enable_pin} = cp[i];
      host.wr(LBC_ADDR_CTRL, cw[i]);
      repeat (3) @(negedge core_clk);
      check("outs", {8'h00, ce[i]}, outs());
    end
    // Voltage codes wait for a control rewrite
    pos_code_req = 6'h05;
    neg_code_req = 6'h02;
    host.wr(LBC_ADDR_CTRL, 8'h86);
    pos_code_req = 6'h09;
    wait_lvl(7'h55, 7'h52);
    host.wr(LBC_ADDR_CTRL, 8'h86);
    wait_lvl(7'h59, 7'h52);
    // Short reaction per mode and filter time
    foreach (fm[i]) begin
      host.wr(LBC_ADDR_RAMP, fm[i]);
      host.wr(LBC_ADDR_FILT, fv[i]);
      host.wr(LBC_ADDR_CTRL, 8'h86);
      repeat (2) @(negedge core_clk);
      {pos_short_raw, neg_short_raw} = 2'h3;
      for (n = 1; n < 2100 && pos_short_event !== 1'b1; n++)
        @(negedge core_clk);
      check("filter", 16'h0001, {15'h0, n >= fl[i] && n <= fl[i] + 3});
      check("neg event", 16'h0001, {15'h0, neg_short_event});
      if (pos_short_event !== 1'b1)
        final_report();
      repeat (3) @(negedge core_clk);
      check("outs", {8'h00, fo[i]}, outs());
      check("backlight", {15'h0, fb[i]}, {15'h0, backlight_shutdown});
      {pos_short_raw, neg_short_raw} = 2'h0;
    end
    // Ramp time follows the rise and fall codes at fixed slew
    host.wr(LBC_ADDR_CTRL, 8'h80);
    host.wr(LBC_ADDR_RAMP, 8'h31);
    host.wr(LBC_ADDR_CTRL, 8'h86);
    m = 0;
    for (n = 0; n < 16000 && pos_level !== 7'h59; n++) begin
      if (neg_level !== 7'h52)
        m = n + 1;
      @(negedge core_clk);
    end
    e = 89 * 4 * LBC_POS_STEP_CYC;
    check("pos ramp", 16'h0001, {15'h0, n >= e - 2 && n <= e + 2});
    e = 82 * 2 * LBC_NEG_STEP_CYC;
    check("neg ramp", 16'h0001, {15'h0, m >= e - 2 && m <= e + 2});
    final_report();
  end
endmodule
